// >>> verilog/dsos_regs.vh
/*
 holds: object indices, subindices, reset values and action encodings of the
 stop option select block.
 assumes: included by bare name from verilog/dsos_stop_select.v.
*/
// What this block does
// - speed in rpm is internal speed times numerator, divided by denominator.
// - numerator and denominator are signed 32-bit read/write, both reset to one.
// - quick stop code 0 immediate, 1 slow ramp, 2 quick ramp, then switch-on-disabled.
// - quick stop code 1 brakes on the mode-dependent slow-down ramp.
// - quick stop codes 5 and 6 brake, then stay in quick stop, energized.
// - quick stop code is signed 16-bit read/write, reset value 2.
// - shutdown code applies from operation enabled to ready; reset value 1.
// - shutdown and disable code 0 blocks the drive; 2 and up, negatives reserved.
// - disable code applies towards switched on; reset 1; 1 is slow ramp.
// - halt code acts while control word bit 8 is set; reset value 1.
// - halt code 1 slow ramp, 2 quick ramp, others reserved.
`ifndef DSOS_REGS_VH
`define DSOS_REGS_VH

// ----------------------------------------
// object dictionary
// ----------------------------------------
`define DSOS_IDX_QUICK_STOP  16'h605A
`define DSOS_IDX_SHUTDOWN    16'h605B
`define DSOS_IDX_DISABLE     16'h605C
`define DSOS_IDX_HALT        16'h605D
`define DSOS_IDX_SPEED_SCALE 16'h604C
`define DSOS_SUB_VAR         8'h00
`define DSOS_SUB_COUNT       8'h00
`define DSOS_SUB_NUMERATOR   8'h01
`define DSOS_SUB_DENOMINATOR 8'h02

// ----------------------------------------
// reset values
// ----------------------------------------
`define DSOS_RST_QUICK_STOP  16'h0002
`define DSOS_RST_SHUTDOWN    16'h0001
`define DSOS_RST_DISABLE     16'h0001
`define DSOS_RST_HALT        16'h0001
`define DSOS_RST_SCALE_COUNT 8'h02
`define DSOS_RST_NUMERATOR   32'h00000001
`define DSOS_RST_DENOMINATOR 32'h00000001

// ----------------------------------------
// option code values and control word
// ----------------------------------------
`define DSOS_CODE_0          16'h0000
`define DSOS_CODE_1          16'h0001
`define DSOS_CODE_2          16'h0002
`define DSOS_CODE_5          16'h0005
`define DSOS_CODE_6          16'h0006
`define DSOS_CW_HALT_BIT     8

// ----------------------------------------
// trigger kinds and stop actions
// ----------------------------------------
`define DSOS_KIND_QUICK      2'h0
`define DSOS_KIND_SHUTDOWN   2'h1
`define DSOS_KIND_DISABLE    2'h2
`define DSOS_KIND_HALT       2'h3
`define DSOS_ACT_NONE        3'h0
`define DSOS_ACT_COAST       3'h1
`define DSOS_ACT_IMMED       3'h2
`define DSOS_ACT_SLOW        3'h3
`define DSOS_ACT_QUICK       3'h4
// decode result: {reserved, hold, toDisabled, action[2:0]}
`define DSOS_DEC_ACT         2:0
`define DSOS_DEC_TODIS       3
`define DSOS_DEC_HOLD        4
`define DSOS_DEC_RSVD        5

`endif

// >>> verilog/dsos_stop_select.v
/*
 holds: stop option select and speed scaling of the drive, with its object
 dictionary access port.
 assumes: the power state machine reports transitions as one-cycle pulses,
 the ramp generators report standstill, all inputs are synchronous to clk.
*/
`timescale 1ns/10ps
`default_nettype none
`include "dsos_regs.vh"

module dsos_stop_select (
   input  wire        clk,
   input  wire        rst_b,
   // object dictionary access
   input  wire        objRead,
   input  wire        objWrite,
   input  wire [15:0] objIndex,
   input  wire [7:0]  objSub,
   input  wire [31:0] objWdata,
   output reg  [31:0] objRdata,
   output reg         objAck,
   output reg         objErr,
   // power state machine side
   input  wire        enterQuickStop,
   input  wire        shutdownTransition,
   input  wire        disableTransition,
   input  wire [15:0] driveControlWord,
   input  wire        quickStopResume,
   input  wire        standstillReached,
   input  wire [31:0] internalSpeed,
   // power stage and ramp generators
   output reg         driveBlock,
   output reg         brakeImmediate,
   output reg         brakeSlowRamp,
   output reg         brakeQuickRamp,
   output reg         stopBusy,
   output reg         holdEnergized,
   output reg         toSwitchOnDisabled,
   output reg         codeReserved,
   output reg  [31:0] speedRpm
);

   // ----------------------------------------
   // states
   // ----------------------------------------
   localparam [2:0] ST_IDLE = 3'h1;
   localparam [2:0] ST_STOP = 3'h2;
   localparam [2:0] ST_HOLD = 3'h4;

   // ----------------------------------------
   // option code decode, shared by all four triggers
   // ----------------------------------------
   function [5:0] decodeCode;
      input [1:0]  kind;
      input [15:0] code;
      reg   [5:0]  res;
      begin
         res = {1'b0, 1'b0, 1'b0, `DSOS_ACT_NONE};
         case (kind)
            `DSOS_KIND_QUICK: begin
               if (code == `DSOS_CODE_0)
                  res = {3'b001, `DSOS_ACT_IMMED};
               else if (code == `DSOS_CODE_1)
                  res = {3'b001, `DSOS_ACT_SLOW};
               else if (code == `DSOS_CODE_2)
                  res = {3'b001, `DSOS_ACT_QUICK};
               else if (code == `DSOS_CODE_5)
                  res = {3'b010, `DSOS_ACT_SLOW};
               else if (code == `DSOS_CODE_6)
                  res = {3'b010, `DSOS_ACT_QUICK};
               else
                  res = {3'b101, `DSOS_ACT_QUICK};
            end
            `DSOS_KIND_SHUTDOWN, `DSOS_KIND_DISABLE: begin
               if (code == `DSOS_CODE_0)
                  res = {3'b000, `DSOS_ACT_COAST};
               else if (code == `DSOS_CODE_1)
                  res = {3'b001, `DSOS_ACT_SLOW};
               else
                  res = {3'b101, `DSOS_ACT_SLOW};
            end
            `DSOS_KIND_HALT: begin
               if (code == `DSOS_CODE_1)
                  res = {3'b010, `DSOS_ACT_SLOW};
               else if (code == `DSOS_CODE_2)
                  res = {3'b010, `DSOS_ACT_QUICK};
               else
                  res = {3'b110, `DSOS_ACT_SLOW};
            end
            default: res = {1'b0, 1'b0, 1'b0, `DSOS_ACT_NONE};
         endcase
         decodeCode = res;
      end
   endfunction

   // ----------------------------------------
   // entry decode, shared by all seven entries
   // ----------------------------------------
   function entryHit;
      input [15:0] index;
      input [7:0]  sub;
      input [15:0] wantIndex;
      input [7:0]  wantSub;
      begin
         entryHit = (index == wantIndex) && (sub == wantSub);
      end
   endfunction

   // ----------------------------------------
   // setting registers
   // ----------------------------------------
   reg [15:0] quickStopCode_reg;
   reg [15:0] shutdownCode_reg;
   reg [15:0] disableCode_reg;
   reg [15:0] haltCode_reg;
   reg [31:0] numerator_reg;
   reg [31:0] denominator_reg;

   wire hitQuick   = entryHit(objIndex, objSub, `DSOS_IDX_QUICK_STOP, `DSOS_SUB_VAR);
   wire hitShut    = entryHit(objIndex, objSub, `DSOS_IDX_SHUTDOWN, `DSOS_SUB_VAR);
   wire hitDisable = entryHit(objIndex, objSub, `DSOS_IDX_DISABLE, `DSOS_SUB_VAR);
   wire hitHalt    = entryHit(objIndex, objSub, `DSOS_IDX_HALT, `DSOS_SUB_VAR);
   wire hitCount   = entryHit(objIndex, objSub, `DSOS_IDX_SPEED_SCALE, `DSOS_SUB_COUNT);
   wire hitNum     = entryHit(objIndex, objSub, `DSOS_IDX_SPEED_SCALE, `DSOS_SUB_NUMERATOR);
   wire hitDen     = entryHit(objIndex, objSub, `DSOS_IDX_SPEED_SCALE, `DSOS_SUB_DENOMINATOR);
   wire hitRw      = hitQuick | hitShut | hitDisable | hitHalt | hitNum | hitDen;
   // codes keep all 16 bits, reserved values too, so a read returns what was written

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         quickStopCode_reg <= `DSOS_RST_QUICK_STOP;
         shutdownCode_reg  <= `DSOS_RST_SHUTDOWN;
         disableCode_reg   <= `DSOS_RST_DISABLE;
         haltCode_reg      <= `DSOS_RST_HALT;
         numerator_reg     <= `DSOS_RST_NUMERATOR;
         denominator_reg   <= `DSOS_RST_DENOMINATOR;
      end else if (objWrite) begin
         if (hitQuick)
            quickStopCode_reg <= objWdata[15:0];
         if (hitShut)
            shutdownCode_reg <= objWdata[15:0];
         if (hitDisable)
            disableCode_reg <= objWdata[15:0];
         if (hitHalt)
            haltCode_reg <= objWdata[15:0];
         if (hitNum)
            numerator_reg <= objWdata;
         if (hitDen)
            denominator_reg <= objWdata;
      end
   end

   // ----------------------------------------
   // access answer, one cycle after the request
   // ----------------------------------------
   reg [31:0] readMux;

   always @* begin
      readMux = 32'h00000000;
      if (hitQuick)
         readMux = {16'h0000, quickStopCode_reg};
      else if (hitShut)
         readMux = {16'h0000, shutdownCode_reg};
      else if (hitDisable)
         readMux = {16'h0000, disableCode_reg};
      else if (hitHalt)
         readMux = {16'h0000, haltCode_reg};
      else if (hitCount)
         readMux = {24'h000000, `DSOS_RST_SCALE_COUNT};
      else if (hitNum)
         readMux = numerator_reg;
      else if (hitDen)
         readMux = denominator_reg;
   end

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         objRdata <= 32'h00000000;
         objAck   <= 1'b0;
         objErr   <= 1'b0;
      end else begin
         // every access is answered, mapped or not, so a host never stalls
         objAck   <= objRead | objWrite;
         // write to the entry count is refused like an unmapped entry
         objErr   <= (objRead & ~(hitRw | hitCount)) | (objWrite & ~hitRw);
         objRdata <= objRead ? readMux : 32'h00000000;
      end
   end

   // ----------------------------------------
   // speed scaling
   // ----------------------------------------
   // combinational divide keeps latency at one cycle; costs area, not cycles
   // factors widened first so the 64-bit product cannot wrap
   wire signed [63:0] speedWide = {{32{internalSpeed[31]}}, internalSpeed};
   wire signed [63:0] numWide   = {{32{numerator_reg[31]}}, numerator_reg};
   wire signed [63:0] speedProd = speedWide * numWide;
   wire signed [63:0] denWide   = {{32{denominator_reg[31]}}, denominator_reg};
   // a zero denominator gives zero, never an undefined quotient
   wire signed [63:0] speedQuot = (denominator_reg == 32'h00000000) ? 64'sh0 : speedProd / denWide;

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b)
         speedRpm <= 32'h00000000;
      else
         speedRpm <= speedQuot[31:0];
   end

   // ----------------------------------------
   // stop sequencer
   // ----------------------------------------
   wire haltReq = driveControlWord[`DSOS_CW_HALT_BIT];

   reg  [2:0] state_reg;
   reg  [2:0] state_next;
   reg  [1:0] kind_reg;
   reg  [1:0] kind_next;
   reg  [5:0] dec_reg;
   reg  [5:0] dec_next;
   reg        toDis_next;

   // quick stop wins over disable, shutdown and halt when they coincide
   always @* begin
      state_next = state_reg;
      kind_next  = kind_reg;
      dec_next   = dec_reg;
      toDis_next = 1'b0;
      case (state_reg)
         ST_IDLE: begin
            // halt is a level, so it is only looked at once nothing else asks
            if (enterQuickStop) begin
               kind_next  = `DSOS_KIND_QUICK;
               dec_next   = decodeCode(`DSOS_KIND_QUICK, quickStopCode_reg);
               state_next = ST_STOP;
            end else if (disableTransition) begin
               kind_next  = `DSOS_KIND_DISABLE;
               dec_next   = decodeCode(`DSOS_KIND_DISABLE, disableCode_reg);
               state_next = ST_STOP;
            end else if (shutdownTransition) begin
               kind_next  = `DSOS_KIND_SHUTDOWN;
               dec_next   = decodeCode(`DSOS_KIND_SHUTDOWN, shutdownCode_reg);
               state_next = ST_STOP;
            end else if (haltReq) begin
               kind_next  = `DSOS_KIND_HALT;
               dec_next   = decodeCode(`DSOS_KIND_HALT, haltCode_reg);
               state_next = ST_STOP;
            end
         end
         ST_STOP: begin
            // sampled action is held here whatever software writes meanwhile
            if (standstillReached) begin
               if (dec_reg[`DSOS_DEC_HOLD])
                  state_next = ST_HOLD;
               else begin
                  toDis_next = dec_reg[`DSOS_DEC_TODIS];
                  state_next = ST_IDLE;
               end
            end
         end
         ST_HOLD: begin
            // halt hold lasts while the bit stands; quick stop hold waits for resume
            if (kind_reg == `DSOS_KIND_HALT) begin
               if (!haltReq)
                  state_next = ST_IDLE;
            end else if (quickStopResume)
               state_next = ST_IDLE;
         end
         default: state_next = ST_IDLE;
      endcase
   end

   // outputs follow the next state, so they move on the trigger edge itself
   wire [2:0] actNext = (state_next == ST_IDLE) ? `DSOS_ACT_NONE : dec_next[`DSOS_DEC_ACT];

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_reg          <= ST_IDLE;
         kind_reg           <= `DSOS_KIND_QUICK;
         dec_reg            <= 6'h00;
         driveBlock         <= 1'b0;
         brakeImmediate     <= 1'b0;
         brakeSlowRamp      <= 1'b0;
         brakeQuickRamp     <= 1'b0;
         stopBusy           <= 1'b0;
         holdEnergized      <= 1'b0;
         toSwitchOnDisabled <= 1'b0;
         codeReserved       <= 1'b0;
      end else begin
         state_reg          <= state_next;
         kind_reg           <= kind_next;
         dec_reg            <= dec_next;
         driveBlock         <= actNext == `DSOS_ACT_COAST;
         brakeImmediate     <= actNext == `DSOS_ACT_IMMED;
         brakeSlowRamp      <= actNext == `DSOS_ACT_SLOW;
         brakeQuickRamp     <= actNext == `DSOS_ACT_QUICK;
         stopBusy           <= state_next == ST_STOP;
         holdEnergized      <= state_next == ST_HOLD;
         toSwitchOnDisabled <= toDis_next;
         codeReserved       <= (state_next != ST_IDLE) & dec_next[`DSOS_DEC_RSVD];
      end
   end

endmodule
`default_nettype wire

// >>> test/dsos_ramp_model.sv
/*
 holds: ramp generator stand-in that reports standstill after a set delay.
 assumes: bench clock and reset; delayCycles of at least 1.
*/
`timescale 1ns/10ps
`default_nettype none
module dsos_ramp_model (
   input  wire logic       clk,
   input  wire logic       rst_b,
   input  wire logic       stopBusy,
   input  wire logic [7:0] delayCycles,
   output var  logic       standstillReached
);
   logic [7:0] cnt_reg;
   // ----------------
   // ramp
   // ----------------
   // a pulse, not a level: a held level would end the next stop at once
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_reg <= 8'h00;
         standstillReached <= 1'b0;
      end else begin
         cnt_reg <= stopBusy ? cnt_reg + 8'h01 : 8'h00;
         standstillReached <= stopBusy && (cnt_reg + 8'h01 == delayCycles);
      end
   end
endmodule
`default_nettype wire

// >>> test/dsos_stop_select_chk.sv
/*
 holds: port checks of the stop select block.
 assumes: bound to dsos_stop_select, one clock domain.
*/
`timescale 1ns/10ps
`default_nettype none
`include "dsos_regs.vh"
module dsos_stop_select_chk (
   input wire logic        clk,
   input wire logic        rst_b,
   input wire logic        objRead,
   input wire logic        objWrite,
   input wire logic [15:0] objIndex,
   input wire logic [7:0]  objSub,
   input wire logic [31:0] objWdata,
   input wire logic        objAck,
   input wire logic        objErr,
   input wire logic        enterQuickStop,
   input wire logic        shutdownTransition,
   input wire logic        disableTransition,
   input wire logic [15:0] driveControlWord,
   input wire logic        standstillReached,
   input wire logic        driveBlock,
   input wire logic        brakeImmediate,
   input wire logic        brakeSlowRamp,
   input wire logic        brakeQuickRamp,
   input wire logic        stopBusy,
   input wire logic        holdEnergized,
   input wire logic        toSwitchOnDisabled
);
   // ----------------
   // code shadows
   // ----------------
   logic [15:0] qsCode_reg;
   logic [15:0] haltCode_reg;
   logic [2:0]  qsWant;
   logic        idle;
   // the pulse cycle is left out: whether a trigger is taken there is open
   assign idle = !stopBusy && !holdEnergized && !toSwitchOnDisabled;
   assign qsWant = (qsCode_reg == 16'h0000) ? 3'b100 :
                   (qsCode_reg == 16'h0001 || qsCode_reg == 16'h0005) ? 3'b010 : 3'b001;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         qsCode_reg <= `DSOS_RST_QUICK_STOP;
         haltCode_reg <= `DSOS_RST_HALT;
      end else if (objWrite && objSub == 8'h00) begin
         if (objIndex == `DSOS_IDX_QUICK_STOP) qsCode_reg <= objWdata[15:0];
         if (objIndex == `DSOS_IDX_HALT) haltCode_reg <= objWdata[15:0];
      end
   end
   // ----------------
   // assertions
   // ----------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   AST_ACK: assert property ((objRead || objWrite) |=> objAck)
      else $error("access without ack");
   AST_NO_ACK: assert property (!(objRead || objWrite) |=> !objAck && !objErr)
      else $error("ack without access");
   AST_COUNT_RO: assert property (objWrite && objIndex == 16'h604C && objSub == 8'h00 |=> objErr)
      else $error("entry count write accepted");
   AST_QS_CODE: assert property (idle && enterQuickStop |=> stopBusy &&
      {brakeImmediate, brakeSlowRamp, brakeQuickRamp} == $past(qsWant)) else $error("quick stop action wrong");
   AST_HALT_CODE: assert property (idle && !enterQuickStop && !shutdownTransition && !disableTransition &&
      driveControlWord[8] |=> stopBusy && brakeQuickRamp == ($past(haltCode_reg) == 16'h0002))
      else $error("halt action wrong");
   AST_HOLD_RUN: assert property (stopBusy && !standstillReached |=> stopBusy &&
      $stable({driveBlock, brakeImmediate, brakeSlowRamp, brakeQuickRamp})) else $error("stop action changed");
   AST_END: assert property (stopBusy && standstillReached |=> !stopBusy)
      else $error("stop not ended");
   AST_SOD_PULSE: assert property (toSwitchOnDisabled |=> !toSwitchOnDisabled)
      else $error("switch-on-disabled request too long");
   AST_HOLD_STATE: assert property (holdEnergized |-> !stopBusy && (brakeSlowRamp || brakeQuickRamp))
      else $error("hold without brake");
   AST_ONE_ACTION: assert property ($onehot0({driveBlock, brakeImmediate, brakeSlowRamp, brakeQuickRamp}))
      else $error("two stop actions at once");
   cover property (idle && enterQuickStop);
   cover property (holdEnergized);
   cover property (toSwitchOnDisabled);
   cover property (objErr);
endmodule
bind dsos_stop_select dsos_stop_select_chk u_chk (.clk(clk), .rst_b(rst_b), .objRead(objRead),
   .objWrite(objWrite), .objIndex(objIndex), .objSub(objSub), .objWdata(objWdata), .objAck(objAck),
   .objErr(objErr), .enterQuickStop(enterQuickStop), .shutdownTransition(shutdownTransition),
   .disableTransition(disableTransition), .driveControlWord(driveControlWord),
   .standstillReached(standstillReached), .driveBlock(driveBlock), .brakeImmediate(brakeImmediate),
   .brakeSlowRamp(brakeSlowRamp), .brakeQuickRamp(brakeQuickRamp), .stopBusy(stopBusy),
   .holdEnergized(holdEnergized), .toSwitchOnDisabled(toSwitchOnDisabled));
`default_nettype wire

// >>> test/dsos_stop_select_test.sv
/*
 holds: self-checking bench of the stop select block.
 assumes: ramp model and checker compiled first; inputs change at falling edges.
*/
`timescale 1ns/10ps
`default_nettype none
module dsos_stop_select_test;
   logic        clk = 1'b0, rst_b = 1'b0, objRead = 1'b0, objWrite = 1'b0, quickStopResume = 1'b0;
   logic        enterQuickStop = 1'b0, shutdownTransition = 1'b0, disableTransition = 1'b0;
   logic [15:0] objIndex = 16'h0000, driveControlWord = 16'h0000, lfsrState = 16'h7586;
   logic [7:0]  objSub = 8'h00, delayCycles = 8'h05;
   logic [31:0] objWdata = 32'h0, internalSpeed = 32'h0, objRdata, speedRpm;
   logic        objAck, objErr, standstillReached, driveBlock, brakeImmediate, brakeSlowRamp, brakeQuickRamp;
   logic        stopBusy, holdEnergized, toSwitchOnDisabled, codeReserved;
   int          errCount = 0, samplesChecked = 0;
   dsos_stop_select u_dut (.clk(clk), .rst_b(rst_b), .objRead(objRead), .objWrite(objWrite),
      .objIndex(objIndex), .objSub(objSub), .objWdata(objWdata), .objRdata(objRdata), .objAck(objAck),
      .objErr(objErr), .enterQuickStop(enterQuickStop), .shutdownTransition(shutdownTransition),
      .disableTransition(disableTransition), .driveControlWord(driveControlWord),
      .quickStopResume(quickStopResume), .standstillReached(standstillReached), .internalSpeed(internalSpeed),
      .driveBlock(driveBlock), .brakeImmediate(brakeImmediate), .brakeSlowRamp(brakeSlowRamp),
      .brakeQuickRamp(brakeQuickRamp), .stopBusy(stopBusy), .holdEnergized(holdEnergized),
      .toSwitchOnDisabled(toSwitchOnDisabled), .codeReserved(codeReserved), .speedRpm(speedRpm));
   dsos_ramp_model u_ramp (.clk(clk), .rst_b(rst_b), .stopBusy(stopBusy), .delayCycles(delayCycles),
      .standstillReached(standstillReached));
   // ----------------
   // helpers
   // ----------------
   function automatic logic [15:0] rnd();
      lfsrState = {lfsrState[14:0], lfsrState[15] ^ lfsrState[13] ^ lfsrState[12] ^ lfsrState[10]};
      return lfsrState;
   endfunction
   // {reserved, hold, switch-on-disabled, block, immediate, slow, quick}
   function automatic logic [6:0] expStop(input logic [1:0] kind, input logic [15:0] code);
      if (kind == 2'h0) return (code == 16'h0000) ? 7'h14 : (code == 16'h0001) ? 7'h12 : (code == 16'h0002) ? 7'h11 :
         (code == 16'h0005) ? 7'h22 : (code == 16'h0006) ? 7'h21 : 7'h51;
      if (kind == 2'h3) return (code == 16'h0001) ? 7'h22 : (code == 16'h0002) ? 7'h21 : 7'h62;
      return (code == 16'h0000) ? 7'h08 : (code == 16'h0001) ? 7'h12 : 7'h52;
   endfunction
   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      samplesChecked++;
      if (got !== exp) begin
         errCount++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic access(input logic wr, input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] wd,
                         output logic [31:0] rd, output logic err);
      @(negedge clk);
      objRead = !wr;
      objWrite = wr;
      objIndex = idx;
      objSub = sub;
      objWdata = wd;
      @(negedge clk);
      objRead = 1'b0;
      objWrite = 1'b0;
      check("objAck", 32'h1, 32'(objAck));
      rd = objRdata;
      err = objErr;
   endtask
   task automatic runStop(input logic [1:0] kind, input logic [15:0] code);
      logic [31:0] rd;
      logic        e;
      logic [6:0]  w;
      logic [15:0] t;
      w = expStop(kind, code);
      t = rnd();
      delayCycles = 8'h05 + {4'h0, t[3:0]};
      access(1'b1, 16'h605A + 16'(kind), 8'h00, {16'h0, code}, rd, e);
      @(negedge clk);
      enterQuickStop = (kind == 2'h0);
      shutdownTransition = (kind == 2'h1);
      disableTransition = (kind == 2'h2);
      driveControlWord = {7'h00, kind == 2'h3, t[15:8]};
      @(negedge clk);
      enterQuickStop = 1'b0;
      shutdownTransition = 1'b0;
      disableTransition = 1'b0;
      check("stop action", 32'(w[3:0]), 32'({driveBlock, brakeImmediate, brakeSlowRamp, brakeQuickRamp}));
      check("codeReserved", 32'(w[6]), 32'(codeReserved));
      // a later code write must not disturb the running stop
      access(1'b1, 16'h605A + 16'(kind), 8'h00, {16'h0, code ^ 16'h0003}, rd, e);
      check("held action", 32'(w[3:0]), 32'({driveBlock, brakeImmediate, brakeSlowRamp, brakeQuickRamp}));
      for (int i = 0; i < 40 && stopBusy !== 1'b0; i++) @(negedge clk);
      check("stopBusy", 32'h0, 32'(stopBusy));
      check("toSwitchOnDisabled", 32'(w[4]), 32'(toSwitchOnDisabled));
      check("holdEnergized", 32'(w[5]), 32'(holdEnergized));
      @(negedge clk);
      quickStopResume = (kind == 2'h0);
      driveControlWord[8] = 1'b0;
      @(negedge clk);
      quickStopResume = 1'b0;
      @(negedge clk);
      check("released", 32'h0, 32'({holdEnergized, driveBlock, brakeImmediate, brakeSlowRamp, brakeQuickRamp}));
   endtask
   task automatic finalReport();
      $display("comparisons %0d mismatches %0d", samplesChecked, errCount);
      if (errCount == 0 && samplesChecked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // ----------------
   // sequence
   // ----------------
   initial begin
      forever #4 clk = ~clk;
   end
   initial begin
      #100000;
      errCount++;
      finalReport();
   end
   initial begin
      logic [31:0] rd, x, n, d, s;
      logic        e;
      static logic [17:0] cases [16] = '{18'h00000, 18'h00001, 18'h00002, 18'h00005, 18'h00006, 18'h00003,
         18'h10000, 18'h10001, 18'h10002, 18'h20000, 18'h20001, 18'h2FFFF, 18'h30001, 18'h30002, 18'h30000, 18'h38000};
      static logic [31:0] rstVal [7] = '{32'h2, 32'h1, 32'h1, 32'h1, 32'h2, 32'h1, 32'h1};
      repeat (12) @(negedge clk);
      rst_b = 1'b1;
      for (int k = 0; k < 7; k++) begin
         access(1'b0, (k < 4) ? 16'h605A + 16'(k) : 16'h604C, (k < 4) ? 8'h00 : 8'(k - 4), 32'h0, rd, e);
         check("reset value", rstVal[k], rd);
      end
      for (int k = 0; k < 7; k++) begin
         x = {rnd(), rnd()};
         access(1'b1, (k < 4) ? 16'h605A + 16'(k) : 16'h604C, (k < 4) ? 8'h00 : 8'(k - 4), x, rd, e);
         check("write refused", 32'(k == 4), 32'(e));
         access(1'b0, (k < 4) ? 16'h605A + 16'(k) : 16'h604C, (k < 4) ? 8'h00 : 8'(k - 4), 32'h0, rd, e);
         check("readback", (k == 4) ? 32'h2 : (k < 4) ? {16'h0, x[15:0]} : x, rd);
      end
      access(1'b0, 16'h6000, 8'h00, 32'h0, rd, e);
      check("unmapped", 32'h1, 32'(e));
      for (int k = 0; k < 22; k++) begin
         x = {rnd(), rnd()};
         if (k < 16) runStop(cases[k][17:16], cases[k][15:0]);
         else runStop(x[17:16], x[2:0] == 3'h7 ? x[15:0] : {13'h0, x[2:0]});
      end
      for (int k = 0; k < 10; k++) begin
         x = {rnd(), rnd()};
         s = {{16{x[15]}}, x[15:0]};
         n = (k == 1) ? 32'd60 : {{22{x[25]}}, x[25:16]};
         d = (k == 0) ? 32'h0 : (k == 1) ? 32'h1 : {{28{x[31]}}, x[31:28] | 4'h1};
         access(1'b1, 16'h604C, 8'h01, n, rd, e);
         access(1'b1, 16'h604C, 8'h02, d, rd, e);
         internalSpeed = s;
         @(negedge clk);
         check("speedRpm", (d == 32'h0) ? 32'h0 : 32'($signed(s) * $signed(n) / $signed(d)), speedRpm);
      end
      finalReport();
   end
endmodule
`default_nettype wire
